// ### lmu_pkg.sv
// lmu_pkg: constants, states and carrier structs for the lighting unit mode sequencer
// assumes a 40 MHz system clock standing in for the internal resistor-set oscillator
package lmu_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] LMU_ADDR_ENABLES = 8'h08;
	localparam logic [7:0] LMU_ADDR_VOUT = 8'h0D;
	localparam logic [7:0] LMU_ADDR_FREQ = 8'h0E;
	localparam logic [7:0] LMU_ADDR_SWRST = 8'h60;
	// enables register field positions
	localparam int LMU_BIT_ACTIVE = 0;
	localparam int LMU_BIT_BOOST_EN = 1;
	localparam int LMU_BIT_AUTOLOAD = 2;
	// reset values
	localparam logic [7:0] LMU_RST_ENABLES = 8'h06;
	localparam logic [7:0] LMU_RST_VOUT = 8'h3F;
	localparam logic [7:0] LMU_RST_FREQ = 8'h07;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int LMU_CLK_HZ = 40000000;
	localparam int LMU_STARTUP_MS = 10;
	localparam int LMU_STARTUP_CYC = LMU_CLK_HZ / 1000 * LMU_STARTUP_MS;
	// switching period in clocks per frequency choice (40/2, 40/1.67, 40/1)
	localparam logic [5:0] LMU_PER_2M = 6'h14;
	localparam logic [5:0] LMU_PER_1M67 = 6'h18;
	localparam logic [5:0] LMU_PER_1M = 6'h28;
	// minimum switch pulse of 25 ns is one clock
	localparam int LMU_MIN_PULSE_NS = 25;
	localparam logic [5:0] LMU_MIN_PULSE_CYC = 6'((LMU_MIN_PULSE_NS * LMU_CLK_HZ + 999999999) / 1000000000);
	// duty limit: switch on at most this many clocks of each 2 MHz period
	localparam logic [5:0] LMU_MAX_ON_2M = 6'h11;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {LMU_RESET, LMU_STANDBY, LMU_INT_START, LMU_BOOST_START, LMU_NORMAL} lmu_mode_t;
	typedef struct packed {
		logic wr; // one-cycle write strobe
		logic [7:0] addr; // register address
		logic [7:0] data; // write data
	} lmu_wr_t;
	typedef struct packed {
		logic over_current; // switch node voltage too high
		logic over_voltage; // battery well above target
		logic want_on; // regulation loop requests on-time
	} lmu_prot_t;
endpackage

// ### lmu_switch_gen.sv
// lmu_switch_gen: boost power switch pulse generator
// assumes period and duty limit are stable within a cycle
`timescale 1ns/10ps
module lmu_switch_gen
	import lmu_pkg::*;
(
	input wire logic sys_clk, // system clock
	input wire logic rst_n_s, // synchronised reset, active low
	input wire logic run, // converter running
	input wire logic pfm, // soft start pulse-frequency mode
	input wire logic autoload_en, // active load enabled
	input wire logic [5:0] period, // clocks per switching cycle
	input wire lmu_prot_t prot, // protection and loop inputs
	output logic sw_on, // power switch gate
	output logic bleed_on // active load gate
);
	logic [5:0] cnt_ff;
	logic sw_ff;
	logic bleed_ff;
	logic [5:0] max_on;
	logic cyc_end;
	logic min_phase;
	logic nxt_sw;
	logic inhibit;

	// ----------------------------------------
	// cycle counter and switch decision
	// ----------------------------------------
	assign max_on = period - 6'h03;
	assign cyc_end = (cnt_ff >= period - 6'h01);
	assign min_phase = (cnt_ff < LMU_MIN_PULSE_CYC);
	assign inhibit = !run || prot.over_voltage;
	// min pulse forced every cycle unless autoload off and no demand; pfm pulses only on demand
	assign nxt_sw = !inhibit && !prot.over_current && (cnt_ff < max_on) &&
		(prot.want_on || (min_phase && autoload_en && !pfm));

	always_ff @(posedge sys_clk or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			cnt_ff <= 6'h00;
			sw_ff <= 1'b0;
			bleed_ff <= 1'b0;
		end
		else
		begin
			cnt_ff <= (cyc_end || !run) ? 6'h00 : cnt_ff + 6'h01;
			sw_ff <= nxt_sw;
			bleed_ff <= run && autoload_en && !prot.want_on;
		end
	end

	assign sw_on = sw_ff;
	assign bleed_on = bleed_ff;

	chk_oc_cuts: assert property (@(posedge sys_clk) disable iff (!rst_n_s)
		prot.over_current |=> !sw_ff) else $error("switch on during over-current");
	chk_ov_inhibit: assert property (@(posedge sys_clk) disable iff (!rst_n_s)
		prot.over_voltage |=> !sw_ff) else $error("switch on during over-voltage");
	chk_no_bleed: assert property (@(posedge sys_clk) disable iff (!rst_n_s)
		!autoload_en |=> !bleed_ff) else $error("active load on while disabled");
endmodule

// ### lmu_mode_seq.sv
// lmu_mode_seq: operating-mode sequencer and boost digital control
// assumes register writes arrive as one-cycle strobes from the serial interface decoder
// Functional notes
// - any reset restores register defaults, clears active request, then goes standby
// - reset held while reset pin low or power-on reset active
// - any write to software reset register resets the whole device
// - when power-on reset releases, device proceeds into standby
// - active request low keeps device in standby, all functions off
// - standby accepts register writes, taking effect at power up
// - active request high runs internal startup with 10 ms delay
// - thermal shutdown disables chip, holds startup until it clears
// - boost startup after internal startup if enabled, or on enable write
// - boost startup ramps in PFM for 10 ms, then PWM
// - all LED outputs forced off during boost startup
// - normal mode accepts writes in any order, any bits at once
// - output voltage chosen by 8-bit thermometer register, nine levels
// - three switching frequencies, highest by default
// - converter and all timing derive from one oscillator
// - minimum switch pulse every cycle to avoid skipping
// - clearing autoload bit stops active load; skipping then allowed
// - over-current turns power switch off for that cycle; the code holds it off only in the clock after each over-current sample
// - over-voltage inhibits converter switching
// - duty cycle limited digitally
// - converter enable low stops boost; high again restarts via soft start
// - frequency select 1XX 2 MHz, 01X 1.67 MHz, 001 1 MHz, default 07H
// - output voltage register at 0DH, thermometer code, default 3F
`timescale 1ns/10ps
module lmu_mode_seq
	import lmu_pkg::*;
#(
	parameter int STARTUP_CYC = LMU_STARTUP_CYC // shorten in simulation
)
(
	input wire logic sys_clk, // system clock, stands in for the internal oscillator
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic hw_reset_in_low, // reset pin level, active low
	input wire logic por_active, // power-on reset detector, active high
	input wire logic overtemp_shutdown, // thermal shutdown event, active high
	input wire lmu_wr_t reg_wr, // register write strobe
	input wire lmu_prot_t prot, // converter protection and loop inputs
	output lmu_mode_t mode, // current operating mode
	output logic chip_enable, // reference, bias and oscillator enable
	output logic led_force_off, // all LED outputs off
	output logic boost_pfm, // converter in pulse-frequency mode
	output logic boost_run, // converter enabled
	output logic [7:0] vout_code, // output voltage thermometer code
	output logic [3:0] vout_level, // decoded voltage step 0..8
	output logic [5:0] sw_period, // switching period in clocks
	output logic sw_on, // power switch gate
	output logic bleed_on // active load gate
);
	localparam logic [23:0] DLY_LAST = 24'(STARTUP_CYC - 1);

	// ----------------------------------------
	// reset synchroniser and reset combination
	// ----------------------------------------
	logic rst_s1_ff;
	logic rst_s2_ff;
	logic swrst_ff;
	logic pin_rst_ff;
	logic sys_rst_n;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_s1_ff <= 1'b0;
			rst_s2_ff <= 1'b0;
		end
		else
		begin
			rst_s1_ff <= 1'b1;
			rst_s2_ff <= rst_s1_ff;
		end
	end

	// pin and por are sampled so that the reset net stays glitch free
	always_ff @(posedge sys_clk or negedge rst_s2_ff)
	begin
		if (!rst_s2_ff)
		begin
			pin_rst_ff <= 1'b1;
			swrst_ff <= 1'b0;
		end
		else
		begin
			pin_rst_ff <= !hw_reset_in_low || por_active;
			swrst_ff <= reg_wr.wr && (reg_wr.addr == LMU_ADDR_SWRST);
		end
	end

	assign sys_rst_n = rst_s2_ff && !pin_rst_ff && !swrst_ff;

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	logic [7:0] enables_ff;
	logic [7:0] vout_ff;
	logic [7:0] freq_ff;
	logic wr_en;
	logic wr_vout;
	logic wr_freq;
	logic active_req;
	logic boost_en;
	logic autoload_en;

	// writes land in any mode, standby included, and any bits may change at once
	assign wr_en = reg_wr.wr && (reg_wr.addr == LMU_ADDR_ENABLES);
	assign wr_vout = reg_wr.wr && (reg_wr.addr == LMU_ADDR_VOUT);
	assign wr_freq = reg_wr.wr && (reg_wr.addr == LMU_ADDR_FREQ);

	always_ff @(posedge sys_clk or negedge sys_rst_n)
	begin
		if (!sys_rst_n)
		begin
			enables_ff <= LMU_RST_ENABLES;
			vout_ff <= LMU_RST_VOUT;
			freq_ff <= LMU_RST_FREQ;
		end
		else
		begin
			enables_ff <= wr_en ? reg_wr.data : enables_ff;
			vout_ff <= wr_vout ? reg_wr.data : vout_ff;
			freq_ff <= wr_freq ? reg_wr.data : freq_ff;
		end
	end

	assign active_req = enables_ff[LMU_BIT_ACTIVE];
	assign boost_en = enables_ff[LMU_BIT_BOOST_EN];
	assign autoload_en = enables_ff[LMU_BIT_AUTOLOAD];

	// ----------------------------------------
	// decode of voltage and frequency fields
	// ----------------------------------------
	logic [3:0] nxt_level;
	logic [5:0] nxt_period;

	// thermometer code: count leading ones from bit 0
	always_comb
	begin
		nxt_level = 4'h0;
		for (int i = 0; i < 8; i++)
		begin
			if (vout_ff[i] && (nxt_level == 4'(i)))
				nxt_level = 4'(i + 1);
		end
	end

	// 000 is not a listed code; it falls to the slowest rate as the safest choice
	assign nxt_period = freq_ff[2] ? LMU_PER_2M : (freq_ff[1] ? LMU_PER_1M67 : LMU_PER_1M);

	// ----------------------------------------
	// mode state machine and delay counter
	// ----------------------------------------
	lmu_mode_t mode_ff;
	lmu_mode_t nxt_mode;
	logic [23:0] dly_ff;
	logic dly_done;
	logic boost_en_d_ff;
	logic boost_rise;

	assign dly_done = (dly_ff == DLY_LAST);
	assign boost_rise = boost_en && !boost_en_d_ff;

	always_comb
	begin
		nxt_mode = mode_ff;
		unique case (mode_ff)
			LMU_RESET: nxt_mode = LMU_STANDBY;
			LMU_STANDBY: if (active_req) nxt_mode = LMU_INT_START;
			LMU_INT_START:
			begin
				if (!active_req)
					nxt_mode = LMU_STANDBY;
				else if (dly_done && !overtemp_shutdown)
					nxt_mode = boost_en ? LMU_BOOST_START : LMU_NORMAL;
			end
			LMU_BOOST_START:
			begin
				if (!active_req)
					nxt_mode = LMU_STANDBY;
				else if (overtemp_shutdown)
					nxt_mode = LMU_INT_START;
				else if (!boost_en)
					nxt_mode = LMU_NORMAL;
				else if (dly_done)
					nxt_mode = LMU_NORMAL;
			end
			LMU_NORMAL:
			begin
				if (!active_req)
					nxt_mode = LMU_STANDBY;
				else if (overtemp_shutdown)
					nxt_mode = LMU_INT_START;
				else if (boost_rise)
					nxt_mode = LMU_BOOST_START;
			end
			default: nxt_mode = LMU_RESET;
		endcase
	end

	always_ff @(posedge sys_clk or negedge sys_rst_n)
	begin
		if (!sys_rst_n)
		begin
			mode_ff <= LMU_RESET;
			dly_ff <= 24'h000000;
			boost_en_d_ff <= 1'b0;
		end
		else
		begin
			mode_ff <= nxt_mode;
			// counter restarts on every mode entry and while overheated
			dly_ff <= (nxt_mode != mode_ff || overtemp_shutdown || dly_done) ? 24'h000000 : dly_ff + 24'h000001;
			boost_en_d_ff <= boost_en;
		end
	end

	// ----------------------------------------
	// registered mode outputs
	// ----------------------------------------
	logic chip_en_ff;
	logic led_off_ff;
	logic pfm_ff;
	logic run_ff;
	logic [3:0] level_ff;
	logic [5:0] period_ff;

	always_ff @(posedge sys_clk or negedge sys_rst_n)
	begin
		if (!sys_rst_n)
		begin
			chip_en_ff <= 1'b0;
			led_off_ff <= 1'b1;
			pfm_ff <= 1'b0;
			run_ff <= 1'b0;
			level_ff <= 4'h0;
			period_ff <= LMU_PER_2M;
		end
		else
		begin
			chip_en_ff <= (nxt_mode != LMU_STANDBY) && (nxt_mode != LMU_RESET) && !overtemp_shutdown;
			led_off_ff <= (nxt_mode != LMU_NORMAL);
			pfm_ff <= (nxt_mode == LMU_BOOST_START);
			run_ff <= ((nxt_mode == LMU_BOOST_START) || (nxt_mode == LMU_NORMAL)) && boost_en;
			level_ff <= nxt_level;
			period_ff <= nxt_period;
		end
	end

	assign mode = mode_ff;
	assign chip_enable = chip_en_ff;
	assign led_force_off = led_off_ff;
	assign boost_pfm = pfm_ff;
	assign boost_run = run_ff;
	assign vout_code = vout_ff;
	assign vout_level = level_ff;
	assign sw_period = period_ff;

	// ----------------------------------------
	// power switch
	// ----------------------------------------
	lmu_switch_gen u_sw
	(
		.sys_clk(sys_clk),
		.rst_n_s(sys_rst_n),
		.run(run_ff),
		.pfm(pfm_ff),
		.autoload_en(autoload_en),
		.period(period_ff),
		.prot(prot),
		.sw_on(sw_on),
		.bleed_on(bleed_on)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_boost_entry;
		mode_ff != LMU_BOOST_START ##1 mode_ff == LMU_BOOST_START;
	endsequence

	chk_standby_idle: assert property (@(posedge sys_clk) disable iff (!sys_rst_n)
		(mode_ff == LMU_STANDBY && !active_req) |=> mode_ff == LMU_STANDBY) else $error("left standby");
	chk_reset_next: assert property (@(posedge sys_clk) disable iff (!sys_rst_n)
		mode_ff == LMU_RESET |=> mode_ff == LMU_STANDBY) else $error("reset not followed by standby");
	chk_heat_hold: assert property (@(posedge sys_clk) disable iff (!sys_rst_n)
		(mode_ff == LMU_INT_START && overtemp_shutdown) |=> mode_ff inside {LMU_INT_START, LMU_STANDBY})
		else $error("left startup in thermal shutdown");
	chk_led_off: assert property (@(posedge sys_clk) disable iff (!sys_rst_n)
		mode_ff == LMU_BOOST_START |-> led_off_ff) else $error("leds on in boost startup");
	// a soft start cut short by a disable or by heat is legal, so the second cycle binds only while boost lasts
	chk_pfm_soft: assert property (@(posedge sys_clk) disable iff (!sys_rst_n)
		s_boost_entry |-> pfm_ff ##1 (pfm_ff || mode_ff != LMU_BOOST_START)) else $error("no pfm at boost entry");
	chk_int_delay: assert property (@(posedge sys_clk) disable iff (!sys_rst_n)
		(mode_ff == LMU_INT_START && dly_ff != DLY_LAST) |=> mode_ff != LMU_NORMAL && mode_ff != LMU_BOOST_START)
		else $error("startup delay cut short");
	chk_swrst_acts: assert property (@(posedge sys_clk) disable iff (!rst_s2_ff)
		(reg_wr.wr && reg_wr.addr == LMU_ADDR_SWRST) |=> !sys_rst_n) else $error("software reset ignored");
	chk_freq_dec: assert property (@(posedge sys_clk) disable iff (!sys_rst_n)
		$past(freq_ff[2]) |-> period_ff == LMU_PER_2M) else $error("frequency decode wrong");
endmodule

// ### lmu_host_model.sv
// lmu_host_model: host side of the register path, issues one-cycle writes
// assumes one bench process calls its tasks, never two at once
`timescale 1ns/10ps
module lmu_host_model
	import lmu_pkg::*;
(
	input wire logic sys_clk, // system clock
	output lmu_wr_t reg_wr // write strobe into the sequencer
);
	// ----------------------------------------
	// write tasks
	// ----------------------------------------
	initial reg_wr = '0;
	// driven at the falling edge; released fields show inverted values so stale data never looks valid
	task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
		@(negedge sys_clk);
		reg_wr <= '{wr: 1'b1, addr: addr, data: data};
		@(negedge sys_clk);
		reg_wr <= '{wr: 1'b0, addr: ~addr, data: ~data};
	endtask
	// converter parked while nothing draws current, saves supply current
	task automatic park_boost(input logic [7:0] keep);
		wr_reg(LMU_ADDR_ENABLES, keep & ~(8'h01 << LMU_BIT_BOOST_EN));
	endtask
endmodule

// ### testbench.sv
// testbench: self-checking bench for the mode sequencer with a host model
// assumes a shortened startup delay and inputs driven at the falling edge
`timescale 1ns/10ps
module testbench
	import lmu_pkg::*;
;
	localparam int SC = 20; // shortened startup delay
	logic sys_clk, rst_n, hw_reset_in_low, por_active, overtemp_shutdown;
	logic chip_enable, led_force_off, boost_pfm, boost_run, sw_on, bleed_on;
	logic [7:0] vout_code;
	logic [3:0] vout_level;
	logic [5:0] sw_period;
	lmu_wr_t reg_wr;
	lmu_prot_t prot;
	lmu_mode_t mode;
	int miscompares = 0;
	int checks_done = 0;
	int n;
	logic [31:0] seed = 32'h1B96121D;
	logic [7:0] v;
	logic [7:0] fsel [4] = '{8'h01, 8'h02, 8'h00, 8'h07};
	logic [2:0] pv [4] = '{3'h1, 3'h0, 3'h3, 3'h5};
	int pe [4] = '{34, 2, 0, 0};
	lmu_mode_seq #(.STARTUP_CYC(SC)) i_lmu_mode_seq (.sys_clk(sys_clk), .rst_n(rst_n),
		.hw_reset_in_low(hw_reset_in_low), .por_active(por_active), .overtemp_shutdown(overtemp_shutdown),
		.reg_wr(reg_wr), .prot(prot), .mode(mode), .chip_enable(chip_enable), .led_force_off(led_force_off),
		.boost_pfm(boost_pfm), .boost_run(boost_run), .vout_code(vout_code), .vout_level(vout_level),
		.sw_period(sw_period), .sw_on(sw_on), .bleed_on(bleed_on));
	lmu_host_model i_lmu_host_model (.sys_clk(sys_clk), .reg_wr(reg_wr));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xorshift(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction
	// voltage step is the run of ones counted up from bit 0
	function automatic logic [3:0] exp_level(input logic [7:0] c);
		logic [3:0] k;
		k = 4'h0;
		while (k < 4'h8 && c[k[2:0]])
			k++;
		return k;
	endfunction
	function automatic logic [5:0] exp_period(input logic [7:0] f);
		return f[2] ? LMU_PER_2M : (f[1] ? LMU_PER_1M67 : LMU_PER_1M);
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_lmu_host_model.wr_reg(a, d);
	endtask
	// bounded wait; a count of 300 means the mode never came
	task automatic wait_mode(input lmu_mode_t m, output int k);
		k = 0;
		while (mode !== m && k < 300)
		begin
			@(negedge sys_clk);
			k++;
		end
	endtask
	task automatic count_on(input int len, output int k);
		k = 0;
		repeat (len)
		begin
			@(negedge sys_clk);
			k += (sw_on === 1'b1) ? 1 : ((sw_on === 1'b0) ? 0 : 100); // an unknown gate spoils the count
		end
	endtask
	task automatic tally_and_finish();
		if (miscompares == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ----------------------------------------
	// clock, watchdog and scenarios
	// ----------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// a hang is cut short well beyond the expected run length
	initial
	begin
		#(25 * 8000);
		miscompares++;
		tally_and_finish();
	end
	initial
	begin
		rst_n = 1'b0;
		hw_reset_in_low = 1'b1;
		por_active = 1'b0;
		overtemp_shutdown = 1'b0;
		prot = '0;
		cyc(3);
		rst_n = 1'b1;
		cyc(4);
		check(mode, LMU_STANDBY);
		check({vout_code, sw_period, chip_enable}, {LMU_RST_VOUT, LMU_PER_2M, 1'b0});
		foreach (fsel[i])
		begin
			wr(LMU_ADDR_FREQ, fsel[i]);
			cyc(2);
			check(sw_period, exp_period(fsel[i]));
		end
		// thermometer corners first, then random codes; all taken while in standby
		for (int i = 0; i < 21; i++)
		begin
			seed = xorshift(seed);
			v = (i < 9) ? (8'hFF >> (8 - i)) : seed[7:0];
			wr(LMU_ADDR_VOUT, v);
			cyc(2);
			check({vout_code, vout_level}, {v, exp_level(v)});
		end
		check(mode, LMU_STANDBY);
		wr(LMU_ADDR_ENABLES, 8'h07);
		wait_mode(LMU_INT_START, n);
		check(n <= 3 && chip_enable === 1'b1, 1'b1);
		wait_mode(LMU_BOOST_START, n);
		check(n >= SC - 1 && n <= SC + 2, 1'b1);
		check({boost_pfm, led_force_off, boost_run}, 3'h7);
		wait_mode(LMU_NORMAL, n);
		check(n >= SC - 1 && n <= SC + 2, 1'b1);
		check({boost_pfm, led_force_off, vout_code}, {2'h0, v});
		cyc(45);
		foreach (pv[i])
		begin
			prot = pv[i];
			cyc(4);
			count_on(40, n);
			check(n, pe[i]);
		end
		// protection released first, so only the autoload bit can stop the minimum pulse
		prot = '0;
		cyc(4);
		check(bleed_on, 1'b1);
		wr(LMU_ADDR_ENABLES, 8'h03);
		cyc(4);
		count_on(40, n);
		check(n, 0);
		check(bleed_on, 1'b0);
		wr(LMU_ADDR_ENABLES, 8'h07);
		overtemp_shutdown = 1'b1;
		wait_mode(LMU_INT_START, n);
		check(n <= 3, 1'b1);
		cyc(3 * SC);
		check({mode, led_force_off, chip_enable}, {LMU_INT_START, 2'h2});
		overtemp_shutdown = 1'b0;
		wait_mode(LMU_BOOST_START, n);
		check(n >= SC - 1 && n <= SC + 2, 1'b1);
		wait_mode(LMU_NORMAL, n);
		i_lmu_host_model.park_boost(8'h07);
		cyc(2);
		check({mode, boost_run}, {LMU_NORMAL, 1'b0});
		wr(LMU_ADDR_ENABLES, 8'h07);
		wait_mode(LMU_BOOST_START, n);
		check(n <= 3, 1'b1);
		wait_mode(LMU_NORMAL, n);
		check(n >= SC - 1 && n <= SC + 2, 1'b1);
		wr(LMU_ADDR_FREQ, 8'h02);
		wr(LMU_ADDR_VOUT, 8'hFF);
		cyc(2);
		check({sw_period, vout_level}, {LMU_PER_1M67, 4'h8});
		wr(LMU_ADDR_ENABLES, 8'h06);
		wait_mode(LMU_STANDBY, n);
		cyc(2 * SC);
		check({mode, chip_enable, boost_run}, {LMU_STANDBY, 2'h0});
		// converter left off: startup goes straight to normal with no soft start
		wr(LMU_ADDR_ENABLES, 8'h05);
		wait_mode(LMU_NORMAL, n);
		check(n >= SC - 1 && n <= SC + 2, 1'b1);
		check({boost_run, boost_pfm, led_force_off}, 3'h0);
		wr(LMU_ADDR_SWRST, seed[15:8]);
		wait_mode(LMU_RESET, n);
		check(n <= 3, 1'b1);
		cyc(2 * SC);
		check({mode, vout_code, sw_period}, {LMU_STANDBY, LMU_RST_VOUT, LMU_PER_2M});
		for (int k = 0; k < 2; k++)
		begin
			hw_reset_in_low = (k != 0);
			por_active = (k == 1);
			cyc(10);
			check({mode, chip_enable}, {LMU_RESET, 1'b0});
			hw_reset_in_low = 1'b1;
			por_active = 1'b0;
			wait_mode(LMU_STANDBY, n);
			check(n <= 4, 1'b1);
		end
		tally_and_finish();
	end
endmodule
